// ==== hw/avos_pkg.sv ====
// Purpose: shared constants and types of the video output sequencer
// Assumes: pixel clock 40 MHz, 20 MHz with binning; system clock 10 MHz
// Notes: gap counts are derived from the printed times, rounded up
package avos_pkg;
  localparam int PIX_W = 10;
  localparam int PIX8_W = 8;
  localparam int PAIR_W = 2 * PIX_W;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W = 11;
  localparam int GAP_W = 11;
  localparam int EXP_W = 16;
  localparam int NS_PER_US = 1000;
  localparam int PIX_MHZ_NORM = 40;
  localparam int PIX_MHZ_BIN = 20;
  localparam int GAP_NOM_NS = 7900;
  localparam int GAP_LONG_NS = 30000;
  localparam int GAP_LAST_NS = 25;
  // cycle counts minus one, as loaded into the gap down-counter
  localparam logic [GAP_W-1:0] GAP_NOM_N =
    GAP_W'((GAP_NOM_NS * PIX_MHZ_NORM + NS_PER_US - 1) / NS_PER_US - 1);
  localparam logic [GAP_W-1:0] GAP_NOM_B =
    GAP_W'((GAP_NOM_NS * PIX_MHZ_BIN + NS_PER_US - 1) / NS_PER_US - 1);
  localparam logic [GAP_W-1:0] GAP_LONG_N =
    GAP_W'((GAP_LONG_NS * PIX_MHZ_NORM + NS_PER_US - 1) / NS_PER_US - 1);
  localparam logic [GAP_W-1:0] GAP_LONG_B =
    GAP_W'((GAP_LONG_NS * PIX_MHZ_BIN + NS_PER_US - 1) / NS_PER_US - 1);
  localparam logic [GAP_W-1:0] GAP_LAST_N =
    GAP_W'((GAP_LAST_NS * PIX_MHZ_NORM + NS_PER_US - 1) / NS_PER_US - 1);
  localparam logic [GAP_W-1:0] GAP_LAST_B =
    GAP_W'((GAP_LAST_NS * PIX_MHZ_BIN + NS_PER_US - 1) / NS_PER_US - 1);
  localparam logic [CNT_W-1:0] FULL_PAIRS = 11'h1F6;
  localparam logic [CNT_W-1:0] FULL_LINES = 11'h3EC;
  typedef enum logic {AVOS_EXP_LEVEL, AVOS_EXP_PROG} avos_exp_mode_e;
  typedef enum logic {EX_IDLE, EX_EXPOSE} avos_exp_state_e;
  typedef enum logic [1:0] {PX_IDLE, PX_GAP, PX_LINE} avos_pix_state_e;
endpackage : avos_pkg

// ==== hw/avos_seq.sv ====
// Purpose: video output sequencer of an area camera, two pixels per clock
// Assumes: pixel clock runs free; pixel source keeps the fifo fed in a line
// Notes: exposure control on clk_sys_i, link logic on falling clk_pix_i

////////////////////////////////////////////////////////////////////////////////
module avos_fifo
  import avos_pkg::*;
#(
  parameter int WIDTH = PAIR_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // fill side
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  // drain side
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic push;
  logic pop;

  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_valid_o = (count_reg != '0);
  assign out_data_o = mem[rd_ptr_reg];

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'h1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'h1;
    end
  end

  // link side shifts on the falling edge
  always_ff @(negedge clk_i) begin
    if (!rstn_i) begin
      count_reg <= '0;
      in_ready_o <= 1'h0;
    end else begin
      count_reg <= count_next;
      in_ready_o <= (count_next < CNT_FULL);
    end
  end

  always_ff @(negedge clk_i) begin
    if (!rstn_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'h1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'h1;
      end
    end
  end

  always_ff @(negedge clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end
endmodule : avos_fifo

////////////////////////////////////////////////////////////////////////////////
module avos_seq
  import avos_pkg::*;
(
  // system clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // configuration from the serial command decoder
  input wire avos_exp_mode_e exp_mode_i,
  input wire logic [EXP_W-1:0] exposure_cycles_i,
  input wire logic reduced_depth_i,
  input wire logic binning_i,
  input wire logic region_of_interest_en_i,
  input wire logic [CNT_W-1:0] roi_lines_i,
  input wire logic [CNT_W-1:0] roi_pairs_i,
  // exposure control
  input wire logic ext_sync_i,
  output logic exposure_active_output_o,
  output logic frame_busy_o,
  // pixel source, pixel clock domain
  input wire logic clk_pix_i,
  input wire logic [PIX_W-1:0] pair_odd_i,
  input wire logic [PIX_W-1:0] pair_even_i,
  input wire logic pair_valid_i,
  output logic pair_ready_o,
  // camera link video
  output logic frame_valid_o,
  output logic line_valid_o,
  output logic [PIX_W-1:0] pix_odd_o,
  output logic [PIX_W-1:0] pix_even_o
);
  function automatic logic [PIX_W-1:0] fmt_pix(input logic [PIX_W-1:0] p,
                                               input logic depth8);
    fmt_pix = depth8 ? PIX_W'(p[PIX_W-1:PIX_W-PIX8_W]) : p;
  endfunction : fmt_pix

  //////////////////////////////////////////////////////////////////////////////
  // system domain: external sync and exposure
  logic ext_sync_meta_reg;
  logic ext_sync_reg;
  logic ext_sync_prev_reg;
  logic sync_rise;
  logic sync_fall;
  logic exp_start;
  logic exp_end;
  avos_exp_state_e exp_state_reg;
  logic [EXP_W-1:0] exp_timer_reg;

  // no reset: the chain tracks the pin during reset, so no false edge follows it
  always_ff @(posedge clk_sys_i) begin
    ext_sync_meta_reg <= ext_sync_i;
    ext_sync_reg <= ext_sync_meta_reg;
    ext_sync_prev_reg <= ext_sync_reg;
  end

  assign sync_rise = ext_sync_reg & ~ext_sync_prev_reg;
  assign sync_fall = ~ext_sync_reg & ext_sync_prev_reg;
  assign exp_start = (exp_mode_i == AVOS_EXP_LEVEL) ? sync_fall : sync_rise;
  assign exp_end = (exp_state_reg == EX_EXPOSE) &&
                   ((exp_mode_i == AVOS_EXP_LEVEL) ? sync_rise :
                    (exp_timer_reg <= 16'h0001));

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      exp_state_reg <= EX_IDLE;
      exp_timer_reg <= '0;
      exposure_active_output_o <= 1'h0;
    end else begin
      case (exp_state_reg)
        EX_IDLE: begin
          if (exp_start) begin
            exp_state_reg <= EX_EXPOSE;
            exp_timer_reg <= exposure_cycles_i;
            exposure_active_output_o <= 1'h1;
          end
        end
        EX_EXPOSE: begin
          exp_timer_reg <= exp_timer_reg - 1'h1;
          if (exp_end) begin
            exp_state_reg <= EX_IDLE;
            exposure_active_output_o <= 1'h0;
          end
        end
        default: exp_state_reg <= EX_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // system domain: frame request handshake and long-gap event
  logic fval_meta_reg;
  logic fval_sys_reg;
  logic ack_meta_reg;
  logic ack_sys_reg;
  logic req_tog_reg;
  logic long_tog_reg;
  logic frame_pend_reg;
  logic req_busy;
  logic launch;
  logic [CNT_W-1:0] snap_lines_reg;
  logic [CNT_W-1:0] snap_pairs_reg;
  logic snap_depth8_reg;
  logic snap_bin_reg;
  logic ack_tog_reg;
  logic fval_reg;

  assign req_busy = (req_tog_reg != ack_sys_reg);
  assign launch = frame_pend_reg & ~req_busy;

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      fval_meta_reg <= 1'h0;
      fval_sys_reg <= 1'h0;
      ack_meta_reg <= 1'h0;
      ack_sys_reg <= 1'h0;
    end else begin
      fval_meta_reg <= fval_reg;
      fval_sys_reg <= fval_meta_reg;
      ack_meta_reg <= ack_tog_reg;
      ack_sys_reg <= ack_meta_reg;
    end
  end

  // readout follows the end of exposure; one end of exposure waits in frame_pend_reg, later ones merge into it
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      frame_pend_reg <= 1'h0;
      req_tog_reg <= 1'h0;
      frame_busy_o <= 1'h0;
    end else begin
      frame_pend_reg <= exp_end | (frame_pend_reg & ~launch);
      if (launch) begin
        req_tog_reg <= ~req_tog_reg;
      end
      frame_busy_o <= frame_pend_reg | req_busy | fval_sys_reg;
    end
  end

  // snapshot stays still until the pixel side acknowledges it
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      snap_lines_reg <= FULL_LINES;
      snap_pairs_reg <= FULL_PAIRS;
      snap_depth8_reg <= 1'h0;
      snap_bin_reg <= 1'h0;
    end else if (launch) begin
      snap_lines_reg <= region_of_interest_en_i ? roi_lines_i : FULL_LINES;
      snap_pairs_reg <= region_of_interest_en_i ? roi_pairs_i : FULL_PAIRS;
      snap_depth8_reg <= reduced_depth_i;
      snap_bin_reg <= binning_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      long_tog_reg <= 1'h0;
    end else if (exp_start && fval_sys_reg) begin
      long_tog_reg <= ~long_tog_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pixel domain: reset, crossings, fifo
  logic prst_meta_reg;
  logic prstn_reg;
  logic req_meta_reg;
  logic req_pix_reg;
  logic long_meta_reg;
  logic long_pix_reg;
  logic long_seen_reg;
  logic long_new;
  logic [PAIR_W-1:0] fifo_data;
  logic fifo_valid;
  logic pop;

  always_ff @(negedge clk_pix_i) begin
    prst_meta_reg <= resetn_i;
    prstn_reg <= prst_meta_reg;
  end

  always_ff @(negedge clk_pix_i) begin
    if (!prstn_reg) begin
      req_meta_reg <= 1'h0;
      req_pix_reg <= 1'h0;
      long_meta_reg <= 1'h0;
      long_pix_reg <= 1'h0;
      long_seen_reg <= 1'h0;
    end else begin
      req_meta_reg <= req_tog_reg;
      req_pix_reg <= req_meta_reg;
      long_meta_reg <= long_tog_reg;
      long_pix_reg <= long_meta_reg;
      long_seen_reg <= long_pix_reg;
    end
  end

  assign long_new = long_pix_reg ^ long_seen_reg;

  avos_fifo #(
    .WIDTH(PAIR_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_pix_i),
    .rstn_i(prstn_reg),
    .in_data_i({pair_even_i, pair_odd_i}),
    .in_valid_i(pair_valid_i),
    .in_ready_o(pair_ready_o),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(pop)
  );

  //////////////////////////////////////////////////////////////////////////////
  // pixel domain: frame and line sequencer
  avos_pix_state_e px_state_reg;
  logic lval_reg;
  logic [CNT_W-1:0] pair_cnt_reg;
  logic [CNT_W-1:0] line_cnt_reg;
  logic [CNT_W-1:0] lines_reg;
  logic [CNT_W-1:0] pairs_reg;
  logic [GAP_W-1:0] gap_cnt_reg;
  logic depth8_reg;
  logic bin_reg;
  logic long_pend_reg;
  logic line_done;
  logic last_line;
  logic last_gap;
  logic long_use;
  logic [GAP_W-1:0] gap_load;

  assign line_done = (pair_cnt_reg == pairs_reg);
  assign last_line = (line_cnt_reg + 1'h1 == lines_reg);
  assign last_gap = (line_cnt_reg + 2'h2 == lines_reg);
  assign long_use = (px_state_reg == PX_LINE) && line_done && !last_line &&
                    !last_gap && long_pend_reg;
  assign pop = fifo_valid && (((px_state_reg == PX_GAP) && (gap_cnt_reg == '0)) ||
                              ((px_state_reg == PX_LINE) && !line_done));

  always_comb begin
    if (last_gap) begin
      gap_load = bin_reg ? GAP_LAST_B : GAP_LAST_N;
    end else if (long_pend_reg) begin
      gap_load = bin_reg ? GAP_LONG_B : GAP_LONG_N;
    end else begin
      gap_load = bin_reg ? GAP_NOM_B : GAP_NOM_N;
    end
  end

  // event arriving as the pending flag is consumed still counts
  always_ff @(negedge clk_pix_i) begin
    if (!prstn_reg) begin
      long_pend_reg <= 1'h0;
    end else if (px_state_reg == PX_IDLE) begin
      long_pend_reg <= 1'h0;
    end else begin
      long_pend_reg <= long_new | (long_pend_reg & ~long_use);
    end
  end

  always_ff @(negedge clk_pix_i) begin
    if (!prstn_reg) begin
      ack_tog_reg <= 1'h0;
      lines_reg <= FULL_LINES;
      pairs_reg <= FULL_PAIRS;
      depth8_reg <= 1'h0;
      bin_reg <= 1'h0;
    end else if ((px_state_reg == PX_IDLE) && (req_pix_reg != ack_tog_reg)) begin
      ack_tog_reg <= req_pix_reg;
      lines_reg <= snap_lines_reg;
      pairs_reg <= snap_pairs_reg;
      depth8_reg <= snap_depth8_reg;
      bin_reg <= snap_bin_reg;
    end
  end

  always_ff @(negedge clk_pix_i) begin
    if (!prstn_reg) begin
      px_state_reg <= PX_IDLE;
      fval_reg <= 1'h0;
      lval_reg <= 1'h0;
      pair_cnt_reg <= '0;
      line_cnt_reg <= '0;
      gap_cnt_reg <= '0;
    end else begin
      case (px_state_reg)
        PX_IDLE: begin
          lval_reg <= 1'h0;
          if (req_pix_reg != ack_tog_reg) begin
            px_state_reg <= PX_GAP;
            fval_reg <= 1'h1;
            line_cnt_reg <= '0;
            gap_cnt_reg <= '0;
          end
        end
        PX_GAP: begin
          if (gap_cnt_reg != '0) begin
            gap_cnt_reg <= gap_cnt_reg - 1'h1;
          end else if (pop) begin
            px_state_reg <= PX_LINE;
            lval_reg <= 1'h1;
            pair_cnt_reg <= 11'h001;
          end
        end
        PX_LINE: begin
          if (line_done) begin
            lval_reg <= 1'h0;
            line_cnt_reg <= line_cnt_reg + 1'h1;
            if (last_line) begin
              px_state_reg <= PX_IDLE;
              fval_reg <= 1'h0;
            end else begin
              px_state_reg <= PX_GAP;
              gap_cnt_reg <= gap_load;
            end
          end else begin
            // underrun drops line valid for that cycle only
            lval_reg <= pop;
            if (pop) begin
              pair_cnt_reg <= pair_cnt_reg + 1'h1;
            end
          end
        end
        default: px_state_reg <= PX_IDLE;
      endcase
    end
  end

  always_ff @(negedge clk_pix_i) begin
    if (!prstn_reg) begin
      pix_odd_o <= '0;
      pix_even_o <= '0;
    end else if (pop) begin
      pix_odd_o <= fmt_pix(fifo_data[PIX_W-1:0], depth8_reg);
      pix_even_o <= fmt_pix(fifo_data[PAIR_W-1:PIX_W], depth8_reg);
    end
  end

  assign frame_valid_o = fval_reg;
  assign line_valid_o = lval_reg;
endmodule : avos_seq

// ==== verification/avos_seq_assertions.sv ====
// Purpose: port timing checks for the video output sequencer
// Assumes: config inputs held steady while a frame is in flight
// Notes: video checks sample on rising pixel clock, mid-cycle
module avos_seq_assertions
  import avos_pkg::*;
(
  // system side
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire avos_exp_mode_e exp_mode_i,
  input wire logic [EXP_W-1:0] exposure_cycles_i,
  input wire logic reduced_depth_i,
  input wire logic binning_i,
  input wire logic region_of_interest_en_i,
  input wire logic [CNT_W-1:0] roi_pairs_i,
  input wire logic ext_sync_i,
  input wire logic exposure_active_output_o,
  input wire logic frame_busy_o,
  // video side
  input wire logic clk_pix_i,
  input wire logic frame_valid_o,
  input wire logic line_valid_o,
  input wire logic [PIX_W-1:0] pix_odd_o,
  input wire logic [PIX_W-1:0] pix_even_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [EXP_W:0] exp_cnt_reg;
  logic [GAP_W:0] gap_cnt_reg;
  logic [CNT_W:0] run_cnt_reg;

  always_ff @(posedge clk_sys_i) begin
    exp_cnt_reg <= exposure_active_output_o ? exp_cnt_reg + 1'b1 : '0;
  end
  // counts low samples inside a frame, so a gap is read at the next rise
  always_ff @(posedge clk_pix_i) begin
    gap_cnt_reg <= (frame_valid_o && !line_valid_o) ? gap_cnt_reg + 1'b1 : '0;
  end
  always_ff @(posedge clk_pix_i) begin
    run_cnt_reg <= line_valid_o ? run_cnt_reg + 1'b1 : '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  lval_in_frame_a:
    assert property (@(posedge clk_pix_i) disable iff (!resetn_i)
      line_valid_o |-> frame_valid_o) else $error("line valid outside frame");
  gap_length_a:
    assert property (@(posedge clk_pix_i) disable iff (!resetn_i)
      $rose(line_valid_o) |-> gap_cnt_reg == 1 ||
      gap_cnt_reg > (binning_i ? GAP_NOM_B : GAP_NOM_N)) else $error("line gap too short");
  line_pairs_a:
    assert property (@(posedge clk_pix_i) disable iff (!resetn_i)
      $fell(line_valid_o) |->
      run_cnt_reg == (region_of_interest_en_i ? roi_pairs_i : FULL_PAIRS))
    else $error("wrong pairs per line");
  frame_end_a:
    assert property (@(posedge clk_pix_i) disable iff (!resetn_i)
      $fell(frame_valid_o) |-> $fell(line_valid_o)) else $error("frame end not at line end");
  depth_eight_a:
    assert property (@(posedge clk_pix_i) disable iff (!resetn_i)
      reduced_depth_i && line_valid_o |->
      pix_odd_o[PIX_W-1:PIX8_W] == 2'h0 && pix_even_o[PIX_W-1:PIX8_W] == 2'h0)
    else $error("upper bits set in eight bit mode");
  level_start_a:
    assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      $fell(ext_sync_i) && exp_mode_i == AVOS_EXP_LEVEL && !exposure_active_output_o
      |-> ##[1:6] exposure_active_output_o) else $error("level exposure not started");
  prog_start_a:
    assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      $rose(ext_sync_i) && exp_mode_i == AVOS_EXP_PROG && !exposure_active_output_o
      |-> ##[1:6] exposure_active_output_o) else $error("prog exposure not started");
  prog_length_a:
    assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      $fell(exposure_active_output_o) && exp_mode_i == AVOS_EXP_PROG |->
      exp_cnt_reg >= exposure_cycles_i && exp_cnt_reg <= exposure_cycles_i + 1)
    else $error("prog exposure length wrong");
  busy_after_a:
    assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      $fell(exposure_active_output_o) |-> ##[0:1] frame_busy_o)
    else $error("no frame after exposure");
endmodule : avos_seq_assertions

bind avos_seq avos_seq_assertions i_chk (
  .clk_sys_i, .resetn_i, .exp_mode_i, .exposure_cycles_i, .reduced_depth_i, .binning_i,
  .region_of_interest_en_i, .roi_pairs_i, .ext_sync_i, .exposure_active_output_o,
  .frame_busy_o, .clk_pix_i, .frame_valid_o, .line_valid_o, .pix_odd_o, .pix_even_o
);

// ==== verification/avos_grabber_model.sv ====
// Purpose: frame grabber stand-in capturing qualified pixel pairs
// Assumes: video outputs change on the falling pixel clock
// Notes: samples on the rising edge, mid-cycle; no backpressure exists
module avos_grabber_model
  import avos_pkg::*;
(
  // video from the camera
  input wire logic clk_pix_i,
  input wire logic frame_valid_i,
  input wire logic line_valid_i,
  input wire logic [PIX_W-1:0] pix_odd_i,
  input wire logic [PIX_W-1:0] pix_even_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [PAIR_W-1:0] pairs[$];
  int gaps[$];
  int lines = 0;
  int frames = 0;
  int gap = 0;
  logic lv_q = 1'b0;
  logic fv_q = 1'b0;

  always @(posedge clk_pix_i) begin
    if (frame_valid_i === 1'b1 && fv_q !== 1'b1) lines = 0;
    if (frame_valid_i === 1'b1 && line_valid_i === 1'b1) begin
      pairs.push_back({pix_odd_i, pix_even_i});
      if (lv_q !== 1'b1 && lines > 0) gaps.push_back(gap);
      if (lv_q !== 1'b1) lines++;
      gap = 0;
    end else if (frame_valid_i === 1'b1) begin
      gap++;
    end
    if (fv_q === 1'b1 && frame_valid_i !== 1'b1) frames++;
    lv_q = line_valid_i;
    fv_q = frame_valid_i;
  end
endmodule : avos_grabber_model

// ==== verification/test_area_camera_video_output_sequencer.sv ====
// Purpose: self-checking bench for the video output sequencer
// Assumes: region of interest always on, to keep frames short
// Notes: link clock 160 ns, offset from the 100 ns system clock
module test_area_camera_video_output_sequencer;
  import avos_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int GN = int'(GAP_NOM_N) + 1;
  localparam int GB = int'(GAP_NOM_B) + 1;
  localparam int GLN = int'(GAP_LONG_N) + 1;
  localparam int GT = int'(GAP_LAST_N) + 1;
  localparam int GTB = int'(GAP_LAST_B) + 1;
  logic clk_sys = 1'b0;
  logic clk_pix = 1'b0;
  logic resetn = 1'b0;
  avos_exp_mode_e exp_mode = AVOS_EXP_LEVEL;
  logic [EXP_W-1:0] exp_cycles = 16'h0014;
  logic depth8 = 1'b0;
  logic binning = 1'b0;
  logic [CNT_W-1:0] roi_lines = 11'h003;
  logic [CNT_W-1:0] roi_pairs = 11'h004;
  logic ext_sync = 1'b1;
  logic [PIX_W-1:0] src_odd = 10'h000;
  logic [PIX_W-1:0] src_even = 10'h000;
  logic src_valid = 1'b0;
  wire logic exp_act, busy, src_ready, fval, lval;
  wire logic [PIX_W-1:0] pix_odd, pix_even;
  int n_errors = 0;
  int compares = 0;

  always #50 clk_sys = ~clk_sys;
  always #80 clk_pix = ~clk_pix;

  avos_seq i_dut (
    .clk_sys_i(clk_sys), .resetn_i(resetn), .exp_mode_i(exp_mode),
    .exposure_cycles_i(exp_cycles), .reduced_depth_i(depth8), .binning_i(binning),
    .region_of_interest_en_i(1'b1), .roi_lines_i(roi_lines), .roi_pairs_i(roi_pairs),
    .ext_sync_i(ext_sync), .exposure_active_output_o(exp_act), .frame_busy_o(busy),
    .clk_pix_i(clk_pix), .pair_odd_i(src_odd), .pair_even_i(src_even),
    .pair_valid_i(src_valid), .pair_ready_o(src_ready), .frame_valid_o(fval),
    .line_valid_o(lval), .pix_odd_o(pix_odd), .pix_even_o(pix_even)
  );
  avos_grabber_model i_grab (
    .clk_pix_i(clk_pix), .frame_valid_i(fval), .line_valid_i(lval),
    .pix_odd_i(pix_odd), .pix_even_i(pix_even)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic err(input string msg);
    n_errors++;
    $display("[ERR] %0t %s", $time, msg);
  endtask : err
  task automatic chk_bit(input logic got, input logic exp, input string msg);
    compares++;
    if (got !== exp) err(msg);
  endtask : chk_bit
  task automatic chk_pair(input logic [PAIR_W-1:0] got, input logic [PAIR_W-1:0] exp);
    compares++;
    if (got !== exp) err("pixel pair mismatch");
  endtask : chk_pair
  task automatic chk_num(input int got, input int exp, input string msg);
    compares++;
    if (got != exp) err(msg);
  endtask : chk_num
  task automatic sys_wait(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : sys_wait
  task automatic wait_lv(input logic v);
    int t;
    t = 0;
    while (lval !== v && t < 5000) begin
      @(posedge clk_pix);
      t++;
    end
    if (lval !== v) begin
      err("line valid wait expired");
      wrap_up;
    end
  endtask : wait_lv
  task automatic wait_frame;
    int t;
    t = 0;
    while (i_grab.frames == 0 && t < 30000) begin
      @(posedge clk_sys);
      t++;
    end
    if (i_grab.frames == 0) begin
      err("frame wait expired");
      wrap_up;
    end
    #2;
  endtask : wait_frame
  task automatic clr;
    i_grab.pairs.delete();
    i_grab.gaps.delete();
    i_grab.frames = 0;
  endtask : clr
  // values spread so that the upper bits toggle too
  function automatic logic [PIX_W-1:0] pv(input int l, input int p);
    return PIX_W'((l * 211 + p * 29 + 515) % 1024);
  endfunction : pv
  task automatic feed(input int nl, input int np);
    int l, p, t;
    l = 0;
    p = 1;
    for (t = 0; l < nl && t < 20000; t++) begin
      @(posedge clk_pix);
      #2;
      src_odd = pv(l, p);
      src_even = pv(l, p + 1);
      src_valid = src_ready;
      if (src_ready === 1'b1) p += 2;
      if (p > 2 * np) begin
        p = 1;
        l++;
      end
    end
    @(posedge clk_pix);
    #2;
    src_valid = 1'b0;
    if (l < nl) err("source stalled");
  endtask : feed
  task automatic chk_frame(input int nl, input int np, input int g[$]);
    logic [PAIR_W-1:0] e;
    chk_num(i_grab.lines, nl, "line count");
    chk_num(i_grab.pairs.size(), nl * np, "pair count");
    for (int i = 0; i < nl * np && i < i_grab.pairs.size(); i++) begin
      e = {pv(i / np, 2 * (i % np) + 1), pv(i / np, 2 * (i % np) + 2)};
      if (depth8) e = {2'h0, e[19:12], 2'h0, e[9:2]};
      chk_pair(i_grab.pairs[i], e);
    end
    chk_num(i_grab.gaps.size(), g.size(), "gap count");
    foreach (g[i]) chk_num(i_grab.gaps[i], g[i], "gap length");
  endtask : chk_frame

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_idle;
    sys_wait(20);
    chk_bit(fval, 1'b0, "frame valid idle");
    chk_bit(lval, 1'b0, "line valid idle");
    chk_bit(exp_act, 1'b0, "exposure idle");
    chk_bit(busy, 1'b0, "busy while idle");
    chk_num(i_grab.pairs.size(), 0, "data while idle");
  endtask : t_idle
  task automatic t_level;
    clr;
    fork
      feed(3, 4);
    join_none
    ext_sync = 1'b0;
    sys_wait(100);
    chk_bit(exp_act, 1'b1, "level exposure start");
    chk_bit(fval, 1'b0, "frame before acquisition");
    ext_sync = 1'b1;
    sys_wait(8);
    chk_bit(exp_act, 1'b0, "level exposure end");
    chk_bit(busy, 1'b1, "busy after exposure");
    wait_frame;
    chk_frame(3, 4, '{GN, GT});
  endtask : t_level
  task automatic t_prog;
    clr;
    exp_mode = AVOS_EXP_PROG;
    depth8 = 1'b1;
    binning = 1'b1;
    roi_lines = 11'h004;
    ext_sync = 1'b0;
    fork
      feed(4, 4);
    join_none
    sys_wait(120);
    chk_bit(src_ready, 1'b0, "full buffer still ready");
    ext_sync = 1'b1;
    sys_wait(6);
    chk_bit(exp_act, 1'b1, "prog exposure start");
    sys_wait(50);
    ext_sync = 1'b0;
    wait_frame;
    chk_frame(4, 4, '{GB, GB, GTB});
  endtask : t_prog
  task automatic t_long;
    clr;
    exp_mode = AVOS_EXP_LEVEL;
    depth8 = 1'b0;
    binning = 1'b0;
    ext_sync = 1'b1;
    fork
      feed(4, 4);
    join_none
    sys_wait(60);
    ext_sync = 1'b0;
    sys_wait(110);
    ext_sync = 1'b1;
    wait_lv(1'b1);
    wait_lv(1'b0);
    sys_wait(50);
    ext_sync = 1'b0;
    sys_wait(8);
    chk_bit(exp_act, 1'b1, "sync fall in frame");
    wait_frame;
    chk_frame(4, 4, '{GN, GLN, GT});
    resetn = 1'b0;
    sys_wait(12);
    chk_bit(exp_act, 1'b0, "exposure in reset");
    chk_bit(src_ready, 1'b0, "ready in reset");
    resetn = 1'b1;
    sys_wait(20);
    chk_bit(src_ready, 1'b1, "ready after reset");
    chk_bit(fval, 1'b0, "frame valid after reset");
  endtask : t_long

  initial begin
    sys_wait(12);
    resetn = 1'b1;
    t_idle;
    t_level;
    t_prog;
    t_long;
    wrap_up;
  end
endmodule : test_area_camera_video_output_sequencer
